// ===== driver_stage.v
`timescale 1ns/10ps
`include "relay_chain_map.vh"
module driver_stage (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       shiftEn,
    input  wire       latchEn,
    input  wire       serialIn,
    output wire       cascadeOut,
    output reg  [7:0] latched
);
    reg [7:0] shiftReg;
    // bit 7 is the oldest bit, leaving on the cascade output
    assign cascadeOut = shiftReg[7];
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shiftReg <= 8'h00;
            latched  <= 8'h00;
        end else begin
            if (shiftEn) begin
                shiftReg <= {shiftReg[6:0], serialIn};
            end
            if (latchEn) begin
                latched <= shiftReg;
            end
        end
    end
endmodule

// ===== host_model.sv
`timescale 1ns/10ps
module host_model (
    input  wire logic ref_clk,
    output logic      sClk,
    output logic      sData,
    output logic      strobe);
    initial begin sClk = 0; sData = 0; strobe = 0; end
    task automatic send(input logic [23:0] p);
        for (int i = 23; i >= 0; i--) begin
            @(posedge ref_clk) begin sClk <= 0; sData <= p[i]; end
            repeat (3) @(posedge ref_clk);
            @(posedge ref_clk) sClk <= 1;
            repeat (3) @(posedge ref_clk);
        end
        // clock parks low, data flips so stale bits never look valid
        @(posedge ref_clk) begin sClk <= 0; sData <= ~p[0]; end
        repeat (3) @(posedge ref_clk);
        @(posedge ref_clk) strobe <= 1;
        repeat (4) @(posedge ref_clk);
        strobe <= 0;
    endtask
endmodule

// ===== relay_chain_map.vh
`ifndef RELAY_CHAIN_MAP_VH
`define RELAY_CHAIN_MAP_VH
`define CHAIN_BYTES       2'h3
`define CHAIN_BITS        5'h18
`define STAGE_BITS        4'h8
`define INPUT_RELAYS      4'hA
`define POLE_BIT          5'h0A
`define DRIVE_IDLE        11'h7FF
`define REF_CLK_NS        100
`define SETTLE_NS         1000
`define SETTLE_CYCLES     4'hA
`endif

// ===== serial_relay_driver_chain.v
// How it works
// - one update is three bytes shifted serially into the cascaded driver latches.
// - every data bit enters on a serial clock edge driven by host.
// - a full stage passes each further bit out its cascade to the next.
// - after three bytes, rising strobe edge copies shifted pattern onto latched outputs.
// - latched pattern reaches relays only while output enable is asserted.
// - driver outputs are active low; low energises the relay.
// - ten outputs drive input relays, one more drives pole configuration relay.
// - safeguard holds active-low output enable high through power-up and power-down.
`timescale 1ns/10ps
`include "relay_chain_map.vh"
module serial_relay_driver_chain (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        serialClk,
    input  wire        serialData,
    input  wire        strobe,
    input  wire        outputEnable_n,
    input  wire        powerGood,
    output reg  [9:0]  inputSwitchRelay_n,
    output reg         poleConfigRelay_n,
    output reg         cascadeOut,
    output reg         driversEnabled_n
);
    reg [1:0] clkSync;
    reg [1:0] dataSync;
    reg [1:0] strobeSync;
    reg [1:0] oeSync;
    reg [1:0] pgSync;
    reg       clkPrev;
    reg       strobePrev;
    reg [3:0] settleCount;
    wire      shiftEdge;
    wire      latchEdge;
    wire      safeOk;
    wire      link01;
    wire      link12;
    wire      chainOut;
    wire [7:0] latch0;
    wire [7:0] latch1;
    wire [7:0] latch2;
    wire [23:0] pattern;
    // data synchroniser is as deep as clock synchroniser: dataSync[1] sampled in same cycle as detected edge
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clkSync    <= 2'h0;
            dataSync   <= 2'h0;
            strobeSync <= 2'h0;
            oeSync     <= 2'h3;
            pgSync     <= 2'h0;
            clkPrev    <= 1'b0;
            strobePrev <= 1'b0;
        end else begin
            clkSync    <= {clkSync[0], serialClk};
            dataSync   <= {dataSync[0], serialData};
            strobeSync <= {strobeSync[0], strobe};
            oeSync     <= {oeSync[0], outputEnable_n};
            pgSync     <= {pgSync[0], powerGood};
            clkPrev    <= clkSync[1];
            strobePrev <= strobeSync[1];
        end
    end
    assign shiftEdge = clkSync[1] & ~clkPrev;
    assign latchEdge = strobeSync[1] & ~strobePrev;
    // power safeguard circuit: enable only after power good held settle time
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            settleCount <= 4'h0;
        end else if (!pgSync[1]) begin
            settleCount <= 4'h0;
        end else if (settleCount != `SETTLE_CYCLES) begin
            settleCount <= settleCount + 4'h1;
        end
    end
    assign safeOk = pgSync[1] && (settleCount == `SETTLE_CYCLES);
    // stage 2 is first in chain, so first bit ends in stage 0 bit 7 at far end
    driver_stage stage2 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .shiftEn    (shiftEdge),
        .latchEn    (latchEdge),
        .serialIn   (dataSync[1]),
        .cascadeOut (link12),
        .latched    (latch2)
    );
    driver_stage stage1 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .shiftEn    (shiftEdge),
        .latchEn    (latchEdge),
        .serialIn   (link12),
        .cascadeOut (link01),
        .latched    (latch1)
    );
    driver_stage stage0 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .shiftEn    (shiftEdge),
        .latchEn    (latchEdge),
        .serialIn   (link01),
        .cascadeOut (chainOut),
        .latched    (latch0)
    );
    assign pattern = {latch0, latch1, latch2};
    // first bit shifted sits at pattern[23]; a set bit energises its relay
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inputSwitchRelay_n <= 10'h3FF;
            poleConfigRelay_n  <= 1'b1;
            cascadeOut         <= 1'b0;
            driversEnabled_n   <= 1'b1;
        end else begin
            cascadeOut       <= chainOut;
            driversEnabled_n <= ~(safeOk & ~oeSync[1]);
            if (safeOk && !oeSync[1]) begin
                inputSwitchRelay_n <= ~pattern[9:0];
                poleConfigRelay_n  <= ~pattern[`POLE_BIT];
            end else begin
                inputSwitchRelay_n <= 10'h3FF;
                poleConfigRelay_n  <= 1'b1;
            end
        end
    end
endmodule

// ===== serial_relay_driver_chain_monitor.sv
`timescale 1ns/10ps
module serial_relay_driver_chain_monitor (
    input wire logic       ref_clk, rst, serialClk, serialData, strobe, outputEnable_n, powerGood,
    input wire logic [9:0] inputSwitchRelay_n,
    input wire logic       poleConfigRelay_n, cascadeOut, driversEnabled_n);
    wire allOff = &inputSwitchRelay_n && poleConfigRelay_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // runs of 8 outlast the sync and edge pipe
    a_reset_idle: assert property (disable iff (1'b0) rst |-> allOff && driversEnabled_n && !cascadeOut)
        else $error("reset state wrong");
    a_pg_blocks: assert property (!powerGood [*4] |-> allOff && driversEnabled_n)
        else $error("relay driven without power");
    a_pg_drop: assert property ($fell(powerGood) |-> ##[1:4] driversEnabled_n)
        else $error("drop not blocked");
    a_settle_wait: assert property ($fell(driversEnabled_n) |-> $past(powerGood, 10))
        else $error("enabled before settle");
    a_oe_blocks: assert property (outputEnable_n [*4] |-> allOff)
        else $error("relay driven with outputs disabled");
    a_hold_latch: assert property ((!strobe && !outputEnable_n && powerGood && !driversEnabled_n) [*8]
        |=> $stable({poleConfigRelay_n, inputSwitchRelay_n}))
        else $error("outputs moved without strobe");
    a_casc_quiet: assert property (!serialClk [*8] |=> $stable(cascadeOut))
        else $error("cascade moved without clock");
    a_casc_rise: assert property (serialClk [*8] |=> $stable(cascadeOut))
        else $error("cascade moved on high clock");
    cover property ($fell(strobe));
    cover property ($changed(cascadeOut));
    cover property ($fell(driversEnabled_n));
endmodule
bind serial_relay_driver_chain serial_relay_driver_chain_monitor mon (.*);

// ===== serial_relay_driver_chain_tb.sv
`timescale 1ns/10ps
module serial_relay_driver_chain_tb;
    logic ref_clk = 0, rst = 0, oe_n = 0, pg = 0;
    wire sClk, sData, strobe, pole, casc, enDrv_n;
    wire [9:0] sw;
    int errors = 0, cmp_count = 0;
    logic [23:0] pats [2] = '{24'h80_0555, 24'h7F_FAAA};
    always #50 ref_clk = ~ref_clk;
    host_model host (.ref_clk(ref_clk), .sClk(sClk), .sData(sData), .strobe(strobe));
    serial_relay_driver_chain DUT (.ref_clk(ref_clk), .rst(rst), .serialClk(sClk), .serialData(sData),
        .strobe(strobe), .outputEnable_n(oe_n), .powerGood(pg), .inputSwitchRelay_n(sw),
        .poleConfigRelay_n(pole), .cascadeOut(casc), .driversEnabled_n(enDrv_n));
    task chk(input logic [10:0] exp, input string msg);
        cmp_count++;
        if ({pole, sw} !== exp) begin errors++; $display("CHECK FAILED %0t %s", $time, msg); end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task t_safeguard;
        host.send(24'hFF_FFFF);
        repeat (8) @(posedge ref_clk);
        chk(11'h7FF, "on while unpowered");
        pg <= 1;
        repeat (8) @(posedge ref_clk);
        chk(11'h7FF, "on before settle");
        repeat (22) @(posedge ref_clk);
        chk(11'h000, "not on after settle");
        cmp_count++;
        if (enDrv_n !== 1'b0) begin errors++; $display("CHECK FAILED %0t enable not shown", $time); end
        $display("safeguard done");
    endtask
    task t_patterns;
        logic [10:0] prev;
        prev = 11'h000;
        foreach (pats[k]) begin
            fork
                host.send(pats[k]);
                begin repeat (100) @(posedge ref_clk); chk(prev, "changed before strobe"); end
            join
            repeat (8) @(posedge ref_clk);
            chk(~pats[k][10:0], "bad relay map");
            cmp_count++;
            if (casc !== pats[k][23]) begin errors++; $display("CHECK FAILED %0t cascade", $time); end
            prev = ~pats[k][10:0];
        end
        $display("patterns done");
    endtask
    task t_gates;
        oe_n <= 1;
        repeat (8) @(posedge ref_clk);
        chk(11'h7FF, "on while disabled");
        cmp_count++;
        if (enDrv_n !== 1'b1) begin errors++; $display("CHECK FAILED %0t disable not shown", $time); end
        oe_n <= 0;
        repeat (8) @(posedge ref_clk);
        chk(~pats[1][10:0], "not restored");
        pg <= 0;
        repeat (8) @(posedge ref_clk);
        chk(11'h7FF, "on after power drop");
        $display("gates done");
    endtask
    initial begin #500_000; errors++; stop_test; end
    initial begin
        rst <= 1;
        repeat (10) @(posedge ref_clk);
        rst <= 0;
        t_safeguard;
        t_patterns;
        t_gates;
        stop_test;
    end
endmodule
